// ===== include/rsc_cfg.svh
// Constants of the reset strap capture block
// Operation
// - Latch all straps when power-on reset ends
// - Capture four-bit boot mode for boot choice
// - Watchdog strap 0 disables, 1 enables
// - Strobe strap 0 active low, 1 high
// - Width strap 0 gives 16-bit, 1 8-bit
// - Hard reset line open drain, both ways
// - Release hard reset 521 clocks after power-on
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Timing in input clock cycles, counter widths in bits
`define RSC_POR_MIN_CLKS     16
`define RSC_HRST_DELAY_CLKS  521
`define RSC_TIMER_W          10
`define RSC_POR_CNT_W        5

// Bus geometry
`define RSC_ADDR_W           4
`define RSC_DATA_W           32

// Register byte offsets
`define RSC_STATUS_OFS       4'h0
`define RSC_CONTROL_OFS      4'h4
`define RSC_TIMER_OFS        4'h8

// Status fields
`define RSC_ST_VALID         0
`define RSC_ST_DRIVING       1
`define RSC_ST_LINE_LOW      2
`define RSC_ST_SHORT_POR     3
`define RSC_ST_EXT_SEEN      4
`define RSC_ST_BOOT_LSB      8
`define RSC_ST_WDT           12
`define RSC_ST_STROBE_HI     13
`define RSC_ST_BYTE_MODE     14

// Control fields
`define RSC_CT_SW_HARD_RESET_IO     0
`define RSC_CT_CLR_EXT       1
`define RSC_CT_CLR_SHORT     2

// Reset values
`define RSC_CONTROL_RST      1'h0
`define RSC_BOOT_RST         4'h0

`endif

// ===== include/rsc_pkg.sv
// Types of the reset strap capture block
package rsc_pkg;

	// Phase of the power-on sequence
	typedef enum logic [1:0] {
		RSC_PH_IN_POR,
		RSC_PH_COUNT,
		RSC_PH_RUN
	} rsc_phase_t;

	// Boot mode selector value
	typedef logic [3:0] rsc_boot_mode_t;

endpackage

// ===== logic/rsc_release_timer.sv
// Countdown that holds the hard reset line after power-on release
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_release_timer
#(
	parameter int unsigned DELAY = `RSC_HRST_DELAY_CLKS,
	parameter int unsigned CW    = `RSC_TIMER_W
)
(
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          reset,
	// Control
	input  wire logic          start,
	input  wire logic          hold,
	// State
	output logic [CW-1:0] count,
	output logic          running,
	output logic          drive
);

	logic [CW-1:0] next_count;
	logic          next_running;
	logic          next_drive;

	// Load on start, count down, drop the drive at zero
	always_comb
	begin
		next_count   = count;
		next_running = running;
		if (start)
		begin
			next_count   = CW'(DELAY - 1);
			next_running = 1'b1;
		end
		else if (running)
		begin
			if (count == '0)
				next_running = 1'b0;
			else
				next_count = count - CW'(1);
		end
		next_drive = hold | start | (running & (count != '0));
	end

	// State registers, line driven from reset
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			count   <= '0;
			running <= 1'b0;
			drive   <= 1'b1;
		end
		else
		begin
			count   <= next_count;
			running <= next_running;
			drive   <= next_drive;
		end
	end

endmodule

// ===== logic/rsc_strap_latch.sv
// Holding register for the captured configuration straps
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_strap_latch
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset,
	// Capture strobe and strap levels
	input  wire logic                    capture,
	input  wire rsc_pkg::rsc_boot_mode_t boot_in,
	input  wire logic                    wdt_in,
	input  wire logic                    strobe_in,
	input  wire logic                    byte_in,
	// Held configuration
	output rsc_pkg::rsc_boot_mode_t      boot_mode,
	output logic                         wdt_enable,
	output logic                         strobe_high,
	output logic                         port_16bit,
	output logic                         valid
);

	rsc_pkg::rsc_boot_mode_t next_boot_mode;
	logic                    next_wdt_enable;
	logic                    next_strobe_high;
	logic                    next_port_16bit;
	logic                    next_valid;

	// Take new levels only on the capture strobe
	always_comb
	begin
		next_boot_mode   = boot_mode;
		next_wdt_enable  = wdt_enable;
		next_strobe_high = strobe_high;
		next_port_16bit  = port_16bit;
		next_valid       = valid;
		if (capture)
		begin
			next_boot_mode   = boot_in;
			next_wdt_enable  = wdt_in;
			next_strobe_high = strobe_in;
			next_port_16bit  = ~byte_in;
			next_valid       = 1'b1;
		end
	end

	// Configuration registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			boot_mode   <= `RSC_BOOT_RST;
			wdt_enable  <= 1'b0;
			strobe_high <= 1'b0;
			port_16bit  <= 1'b0;
			valid       <= 1'b0;
		end
		else
		begin
			boot_mode   <= next_boot_mode;
			wdt_enable  <= next_wdt_enable;
			strobe_high <= next_strobe_high;
			port_16bit  <= next_port_16bit;
			valid       <= next_valid;
		end
	end

endmodule

// ===== logic/rsc_top.sv
// Reset strap capture, hard reset sequencing and register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_top
#(
	parameter int unsigned HRST_DELAY = `RSC_HRST_DELAY_CLKS,
	parameter int unsigned POR_MIN    = `RSC_POR_MIN_CLKS
)
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset,
	// Power-on reset from the board
	input  wire logic                    power_on_reset_in_n,
	// Configuration straps
	input  wire logic [3:0]              boot_mode_sel,
	input  wire logic                    watchdog_enable_strap,
	input  wire logic                    host_strobe_polarity,
	input  wire logic                    host_port_byte_mode,
	// Open-drain hard reset line
	input  wire logic                    hard_reset_io_in_n,
	output logic                         hard_reset_io_out_n,
	output logic                         hard_reset_io_oe,
	// Configuration to the device
	output rsc_pkg::rsc_boot_mode_t      cfg_boot_mode,
	output logic                         watchdog_enable,
	output logic                         host_strobe_active_high,
	output logic                         host_port_16bit,
	output logic                         config_valid,
	output logic                         core_in_reset,
	// Avalon-MM slave
	input  wire logic [`RSC_ADDR_W-1:0]  avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [`RSC_DATA_W-1:0]  avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [`RSC_DATA_W-1:0]       avs_readdata,
	output logic                         avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam int unsigned TW = `RSC_TIMER_W;
	localparam int unsigned PW = `RSC_POR_CNT_W;

	rsc_pkg::rsc_phase_t      phase;
	rsc_pkg::rsc_phase_t      next_phase;
	logic                     por_prev;
	logic                     por_rise;
	logic [PW-1:0]            por_low_cnt;
	logic [PW-1:0]            next_por_low_cnt;
	logic                     short_por;
	logic                     next_short_por;
	logic                     ext_seen;
	logic                     next_ext_seen;
	logic                     sw_hard_reset_io;
	logic                     next_sw_hard_reset_io;
	logic                     next_core_in_reset;
	logic                     tmr_hold;
	logic [TW-1:0]            tmr_count;
	logic                     tmr_running;
	logic                     next_waitrequest;
	logic [`RSC_DATA_W-1:0]   next_readdata;
	logic                     wr_take;
	logic                     ctl_write;
	logic [`RSC_DATA_W-1:0]   status_word;

	// Byte address matches a register word
	function automatic logic rsc_hit(input logic [`RSC_ADDR_W-1:0] addr,
		input logic [`RSC_ADDR_W-1:0] ofs);
		rsc_hit = (addr[`RSC_ADDR_W-1:2] == ofs[`RSC_ADDR_W-1:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Power-on reset edge

	// Rising edge ends the power-on reset
	assign por_rise = power_on_reset_in_n & ~por_prev;

	// Previous level, low after reset so a high level is caught
	always_ff @(posedge clock)
	begin
		if (reset)
			por_prev <= 1'b0;
		else
			por_prev <= power_on_reset_in_n;
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase and short pulse check

	// Track phase, measure the low width of power-on reset
	always_comb
	begin
		next_phase       = phase;
		next_por_low_cnt = por_low_cnt;
		next_short_por   = short_por;
		unique case (phase)
			rsc_pkg::RSC_PH_IN_POR:
				if (por_rise)
					next_phase = rsc_pkg::RSC_PH_COUNT;
			rsc_pkg::RSC_PH_COUNT:
				if (!power_on_reset_in_n)
					next_phase = rsc_pkg::RSC_PH_IN_POR;
				else if (!tmr_running)
					next_phase = rsc_pkg::RSC_PH_RUN;
			rsc_pkg::RSC_PH_RUN:
				if (!power_on_reset_in_n)
					next_phase = rsc_pkg::RSC_PH_IN_POR;
		endcase
		if (!power_on_reset_in_n)
		begin
			if (por_low_cnt != '1)
				next_por_low_cnt = por_low_cnt + PW'(1);
		end
		else
			next_por_low_cnt = '0;
		if (wr_take && rsc_hit(avs_address, `RSC_CONTROL_OFS)
			&& avs_byteenable[0] && avs_writedata[`RSC_CT_CLR_SHORT])
			next_short_por = 1'b0;
		// A release straight out of block reset counted no low cycles: not a pulse
		if (por_rise && (por_low_cnt != '0) && (por_low_cnt < PW'(POR_MIN)))
			next_short_por = 1'b1;
	end

	// Phase registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			phase       <= rsc_pkg::RSC_PH_IN_POR;
			por_low_cnt <= '0;
			short_por   <= 1'b0;
		end
		else
		begin
			phase       <= next_phase;
			por_low_cnt <= next_por_low_cnt;
			short_por   <= next_short_por;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap capture

	// Straps taken on the power-on release edge only
	rsc_strap_latch u_straps
	(
		.clock       (clock),
		.reset       (reset),
		.capture     (por_rise),
		.boot_in     (boot_mode_sel),
		.wdt_in      (watchdog_enable_strap),
		.strobe_in   (host_strobe_polarity),
		.byte_in     (host_port_byte_mode),
		.boot_mode   (cfg_boot_mode),
		.wdt_enable  (watchdog_enable),
		.strobe_high (host_strobe_active_high),
		.port_16bit  (host_port_16bit),
		.valid       (config_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// Hard reset line

	// Held low during power-on reset and on software request
	assign tmr_hold = ~power_on_reset_in_n | sw_hard_reset_io;

	// Release countdown after power-on reset ends
	rsc_release_timer
	#(
		.DELAY (HRST_DELAY),
		.CW    (TW)
	)
	u_timer
	(
		.clock   (clock),
		.reset   (reset),
		.start   (por_rise),
		.hold    (tmr_hold),
		.count   (tmr_count),
		.running (tmr_running),
		.drive   (hard_reset_io_oe)
	);

	// Line is only ever pulled low, never driven high
	assign hard_reset_io_out_n = 1'b0;

	// Line level seen by the core, from anyone pulling it
	always_comb
	begin
		next_core_in_reset = ~hard_reset_io_in_n;
		next_ext_seen      = ext_seen;
		if (ctl_write && avs_writedata[`RSC_CT_CLR_EXT])
			next_ext_seen = 1'b0;
		if (!hard_reset_io_in_n && !hard_reset_io_oe)
			next_ext_seen = 1'b1;
	end

	// Line monitor registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			core_in_reset <= 1'b0;
			ext_seen      <= 1'b0;
		end
		else
		begin
			core_in_reset <= next_core_in_reset;
			ext_seen      <= next_ext_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register slave

	// Status word of the block
	always_comb
	begin
		status_word                                  = '0;
		status_word[`RSC_ST_VALID]                   = config_valid;
		status_word[`RSC_ST_DRIVING]                 = hard_reset_io_oe;
		status_word[`RSC_ST_LINE_LOW]                = core_in_reset;
		status_word[`RSC_ST_SHORT_POR]               = short_por;
		status_word[`RSC_ST_EXT_SEEN]                = ext_seen;
		status_word[`RSC_ST_BOOT_LSB+3:`RSC_ST_BOOT_LSB] = cfg_boot_mode;
		status_word[`RSC_ST_WDT]                     = watchdog_enable;
		status_word[`RSC_ST_STROBE_HI]               = host_strobe_active_high;
		status_word[`RSC_ST_BYTE_MODE]               = ~host_port_16bit;
	end

	// Write completes at the edge that sees waitrequest low
	assign wr_take   = avs_write & ~avs_waitrequest;
	assign ctl_write = wr_take & rsc_hit(avs_address, `RSC_CONTROL_OFS) & avs_byteenable[0];

	// One wait cycle, then answer; unmapped reads give zero
	always_comb
	begin
		next_waitrequest = 1'b1;
		next_readdata    = avs_readdata;
		next_sw_hard_reset_io   = sw_hard_reset_io;
		if ((avs_read || avs_write) && avs_waitrequest)
			next_waitrequest = 1'b0;
		if (avs_read && avs_waitrequest)
		begin
			if (rsc_hit(avs_address, `RSC_STATUS_OFS))
				next_readdata = status_word;
			else if (rsc_hit(avs_address, `RSC_CONTROL_OFS))
				next_readdata = {31'h0, sw_hard_reset_io};
			else if (rsc_hit(avs_address, `RSC_TIMER_OFS))
				next_readdata = {{(`RSC_DATA_W-TW){1'b0}}, tmr_count};
			else
				next_readdata = '0;
		end
		if (ctl_write)
			next_sw_hard_reset_io = avs_writedata[`RSC_CT_SW_HARD_RESET_IO];
	end

	// Bus registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
			sw_hard_reset_io       <= `RSC_CONTROL_RST;
		end
		else
		begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata    <= next_readdata;
			sw_hard_reset_io       <= next_sw_hard_reset_io;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int CHK_RELEASE = HRST_DELAY;

	logic [TW-1:0] chk_since;
	logic          chk_armed;

	// Cycles since the last power-on release
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			chk_since <= '0;
			chk_armed <= 1'b0;
		end
		else if (por_rise)
		begin
			chk_since <= '0;
			chk_armed <= 1'b1;
		end
		else if (!power_on_reset_in_n)
			chk_armed <= 1'b0;
		else if (chk_since != '1)
			chk_since <= chk_since + TW'(1);
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_strap_capture: assert property (por_rise |=> config_valid)
		else $error("straps not marked valid after release");
	a_boot_mode: assert property (por_rise |=> cfg_boot_mode == $past(boot_mode_sel))
		else $error("boot mode not captured");
	a_watchdog_strap: assert property (por_rise |=> watchdog_enable == $past(watchdog_enable_strap))
		else $error("watchdog enable not captured");
	a_strobe_polarity: assert property (por_rise |=> host_strobe_active_high == $past(host_strobe_polarity))
		else $error("strobe polarity not captured");
	a_port_width: assert property (por_rise |=> host_port_16bit != $past(host_port_byte_mode))
		else $error("port width not captured");
	a_line_open_drain: assert property (!power_on_reset_in_n |=> hard_reset_io_oe && !hard_reset_io_out_n)
		else $error("hard reset line not pulled low");
	a_release_hold: assert property (chk_armed && chk_since < TW'(CHK_RELEASE) |-> hard_reset_io_oe)
		else $error("hard reset released early");
	a_release_time: assert property (chk_armed && chk_since == TW'(CHK_RELEASE) && !sw_hard_reset_io
		&& !$past(sw_hard_reset_io) |-> !hard_reset_io_oe)
		else $error("hard reset not released on time");
	a_straps_held: assert property (!por_rise |=> $stable(cfg_boot_mode) && $stable(watchdog_enable)
		&& $stable(host_strobe_active_high) && $stable(host_port_16bit))
		else $error("configuration changed while running");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");
	a_run_released: assert property (phase == rsc_pkg::RSC_PH_RUN
		&& !$past(sw_hard_reset_io) |-> !hard_reset_io_oe)
		else $error("hard reset driven after countdown");

endmodule

// ===== tb/rsc_board_model.sv
// Board side model: power-on reset source and pulled-up hard reset wire
`timescale 1ns/1ps
module rsc_board_model
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Requests from the bench
	input  wire logic       start_por,
	input  wire logic [7:0] por_len,
	input  wire logic       ext_pull,
	// Open-drain driver of the device
	input  wire logic       dut_oe,
	input  wire logic       dut_out_n,
	// Lines into the device
	output logic            por_n,
	output logic            wire_n
);
	logic [7:0] cnt;

	initial por_n = 1'b1;
	initial cnt = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Power-on pulse, low for por_len cycles (16 or more unless told otherwise)
	always @(posedge clock)
	begin
		if (reset)
		begin
			por_n <= 1'b1;
			cnt   <= 8'h00;
		end
		else if (start_por)
		begin
			por_n <= 1'b0;
			cnt   <= por_len;
		end
		else if (cnt > 8'h01)
			cnt <= cnt - 8'h01;
		else if (cnt == 8'h01)
		begin
			cnt   <= 8'h00;
			por_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pull-up wire; every party only pulls low, none drives high
	assign wire_n = ~((dut_oe & ~dut_out_n) | ext_pull);
endmodule

// ===== tb/test_reset_strap_capture.sv
// Testbench of the reset strap capture block
`timescale 1ns/1ps
module test_reset_strap_capture;
	localparam int unsigned D = 20;

	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        start_por = 1'b0;
	logic [7:0]  por_len = 8'h10;
	logic        ext_pull = 1'b0;
	logic [3:0]  boot = 4'h0;
	logic        wdt = 1'b0;
	logic        strb = 1'b0;
	logic        byte_m = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        por_n;
	logic        wire_n;
	logic        oe;
	logic        out_n;
	logic        core_in_reset;
	logic        valid;
	logic        wdt_en;
	logic        strb_hi;
	logic        p16;
	rsc_pkg::rsc_boot_mode_t cfg_boot;
	logic [31:0] q;
	int          num_errors = 0;
	int          n_checks = 0;

	initial forever #5 clock = ~clock;

	rsc_board_model board (.clock(clock), .reset(reset), .start_por(start_por),
		.por_len(por_len), .ext_pull(ext_pull), .dut_oe(oe), .dut_out_n(out_n),
		.por_n(por_n), .wire_n(wire_n));

	rsc_top #(.HRST_DELAY(D)) dut (.clock(clock), .reset(reset),
		.power_on_reset_in_n(por_n), .boot_mode_sel(boot), .watchdog_enable_strap(wdt),
		.host_strobe_polarity(strb), .host_port_byte_mode(byte_m),
		.hard_reset_io_in_n(wire_n), .hard_reset_io_out_n(out_n), .hard_reset_io_oe(oe),
		.cfg_boot_mode(cfg_boot), .watchdog_enable(wdt_en),
		.host_strobe_active_high(strb_hi), .host_port_16bit(p16), .config_valid(valid),
		.core_in_reset(core_in_reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task hang(input string name);
		num_errors++;
		$display("[FAIL] %s expected done seen timeout", name);
		end_sim();
	endtask

	////////////////////////////////////////////////////////////////////////
	// One Avalon transfer, held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_address   <= a;
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_writedata <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			hang("bus answer");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Power-on pulse, strap capture, late strap change and release count
	task t_capture(input logic [3:0] bm, input logic w, s, b, input logic [7:0] len);
		int n;
		n = 0;
		@(posedge clock);
		boot      <= bm;
		wdt       <= w;
		strb      <= s;
		byte_m    <= b;
		por_len   <= len;
		start_por <= 1'b1;
		@(posedge clock);
		start_por <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("oe in por", oe, 1'b1);
		while (por_n !== 1'b1 && n < 300)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 300)
			hang("por release");
		@(posedge clock);
		boot   <= ~bm;
		wdt    <= ~w;
		strb   <= ~s;
		byte_m <= ~b;
		#1;
		chk("boot", cfg_boot, bm);
		chk("wdt", wdt_en, w);
		chk("strobe", strb_hi, s);
		chk("width16", p16, !b);
		chk("valid", valid, 1'b1);
		repeat (D - 1) @(posedge clock);
		#1;
		chk("oe held", oe, 1'b1);
		@(posedge clock);
		#1;
		chk("oe released", oe, 1'b0);
		chk("boot kept", cfg_boot, bm);
		chk("wdt kept", wdt_en, w);
		chk("width kept", p16, !b);
		@(posedge clock);
		#1;
		chk("wire high", core_in_reset, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Registers, software hard reset, outside pull and unmapped place
	task t_regs;
		bus(1'b0, 4'h0, 32'h0);
		chk("status", q, 32'h5a01);
		bus(1'b1, 4'h4, 32'h1);
		repeat (2) @(posedge clock);
		#1;
		chk("sw pull oe", oe, 1'b1);
		chk("core reset", core_in_reset, 1'b1);
		bus(1'b0, 4'h0, 32'h0);
		chk("status sw", q, 32'h5a07);
		bus(1'b0, 4'h4, 32'h0);
		chk("control", q, 32'h1);
		avs_byteenable <= 4'he;
		bus(1'b1, 4'h4, 32'h0);
		avs_byteenable <= 4'hf;
		bus(1'b0, 4'h4, 32'h0);
		chk("control masked", q, 32'h1);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b1, 4'hc, 32'h1);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("control kept", q, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk("timer", q, 32'h0);
		@(posedge clock);
		ext_pull <= 1'b1;
		repeat (2) @(posedge clock);
		ext_pull <= 1'b0;
		#1;
		chk("oe ext", oe, 1'b0);
		bus(1'b0, 4'h0, 32'h0);
		chk("ext seen", q, 32'h5a11);
		bus(1'b1, 4'h4, 32'h2);
		bus(1'b0, 4'h0, 32'h0);
		chk("ext clear", q, 32'h5a01);
		$display("test regs done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Short power-on pulse still captures but is flagged
	task t_short;
		t_capture(4'h3, 1'b0, 1'b1, 1'b0, 8'h04);
		bus(1'b0, 4'h0, 32'h0);
		chk("short flag", q, 32'h2309);
		bus(1'b1, 4'h4, 32'h4);
		bus(1'b0, 4'h0, 32'h0);
		chk("short clear", q, 32'h2301);
		$display("test short done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		#1;
		chk("reset oe", oe, 1'b1);
		chk("reset valid", valid, 1'b0);
		chk("out low", out_n, 1'b0);
		for (int i = 0; i < 16; i++)
			t_capture(4'(i), i[0], i[1], i[2], 8'h10);
		$display("test codes done");
		t_capture(4'ha, 1'b1, 1'b0, 1'b1, 8'h10);
		t_regs();
		t_short();
		end_sim();
	end
endmodule
